/* src/halt_mode_release_control.sv */
/*
  halt mode entry and release control: wake source selection,
  accept or defer decision, macro service return to halt, bus hold.
  assumes the core reports service routine state and executes the
  resume or vector command it is given; pins are asynchronous.
*/
`timescale 1ns/1ps
`include "halt_release_defines.svh"
module halt_mode_release_control
  import halt_release_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // software halt request from the standby control write
  input wire logic halt_request_bit,
  input wire logic halt_write,
  // core state
  input wire logic global_accept_flag,
  input wire logic level3_priority_select,
  input wire isr_state_type nmi_isr,
  input wire logic nmi_pin_isr_running,
  input wire isr_state_type mask_isr,
  // wake sources and the watchdog request, which never wakes
  input wire logic nmi_pin,
  input wire mask_req_type mask_req,
  input wire logic watchdog_req,
  // macro service completion
  input wire logic macro_done,
  input wire logic macro_end_met,
  input wire logic vector_on_end_disable,
  // core bus values
  input wire bus_pins_type core_bus,
  // commands to the core
  output logic halted,
  output logic resume_next,
  output logic vector_nmi,
  output logic vector_mask,
  output logic macro_start,
  output logic nmi_pending,
  output logic mask_pending,
  // external expansion bus pins
  output bus_pins_type pin_bus
);
  typedef enum logic [1:0] {RUN, HALT, MACRO} state_type;
  state_type state_q;
  state_type state_d;

  logic nmi_level;
  logic nmi_level_q;
  mask_req_type req_q;
  logic nmi_pend_q;
  logic mask_pend_q;
  logic resume_q;
  logic vec_nmi_q;
  logic vec_mask_q;
  logic macro_start_q;
  logic [1:0] mask_prio_q;
  // priority of the macro source, kept for the wake that follows its end
  logic [1:0] macro_prio_q;

  wake_pin_sync #(.WIDTH(1)) u_nmi_sync (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .pin_async(nmi_pin),
    .pin_level(nmi_level)
  );

  // ------------------------------------------------------------
  // acceptance decisions
  // ------------------------------------------------------------
  function automatic logic mask_can_accept(input logic [1:0] rp, input isr_state_type isr,
                                           input logic sel, input logic ie);
    mask_can_accept = ie && (!isr.running || (isr.prio > rp) ||
                      (isr.prio == `PRIO_LEVEL3 && rp == `PRIO_LEVEL3 && !sel));
  endfunction

  // priority 0 is highest; nmi pin lower than higher nmi routines
  wire logic nmi_edge = nmi_level && !nmi_level_q;
  wire logic nmi_can_accept = !nmi_isr.running || (!nmi_pin_isr_running && nmi_isr.prio != 2'h0);
  wire logic mask_wake = req_q.valid && !req_q.source_mask_bit && !req_q.macro;
  wire logic macro_wake = req_q.valid && !req_q.source_mask_bit && req_q.macro;
  wire logic mask_ok = mask_can_accept(req_q.prio, mask_isr, level3_priority_select, global_accept_flag);
  wire logic mask_ok_pend = mask_can_accept(mask_prio_q, mask_isr, level3_priority_select, global_accept_flag);
  wire logic mask_ok_macro = mask_can_accept(macro_prio_q, mask_isr, level3_priority_select, global_accept_flag);
  wire logic enter_halt = halt_write && (halt_request_bit == `HALT_ENTER_VALUE);
  wire logic macro_to_mask = macro_done && macro_end_met && (vector_on_end_disable != `VEC_END_HALT_AGAIN);
  wire logic nmi_wake = nmi_edge || nmi_pend_q;
  wire logic wd_ignored = watchdog_req;

  // ------------------------------------------------------------
  // state machine
  // ------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      RUN: begin
        if (enter_halt) begin
          state_d = HALT;
        end
      end
      HALT: begin
        if (nmi_edge || mask_wake) begin
          state_d = RUN;
        end else if (macro_wake) begin
          state_d = MACRO;
        end
      end
      MACRO: begin
        if (macro_done) begin
          state_d = macro_to_mask ? RUN : HALT;
        end
      end
    endcase
  end

  wire logic wake_now = (state_q == HALT) && (nmi_edge || mask_wake);
  wire logic vec_nmi_d = (nmi_wake && nmi_can_accept) && (state_q != HALT || nmi_edge) && !wd_ignored | 
                         (nmi_wake && nmi_can_accept && (state_q != HALT || nmi_edge) && wd_ignored);
  // a maskable wake comes straight from halt or from a macro end
  wire logic halt_mask = (state_q == HALT) && mask_wake && !nmi_edge;
  wire logic macro_mask = (state_q == MACRO) && macro_to_mask;
  wire logic mask_now = halt_mask || macro_mask;
  wire logic mask_now_ok = (halt_mask && mask_ok) || (macro_mask && mask_ok_macro);
  wire logic vec_mask_d = mask_now_ok || (state_q == RUN && mask_pend_q && mask_ok_pend && !vec_nmi_d);
  wire logic defer_mask = mask_now && !mask_now_ok;
  wire logic defer_nmi = (state_q == HALT) && nmi_edge && !nmi_can_accept;
  wire logic [1:0] defer_prio = halt_mask ? req_q.prio : macro_prio_q;
  wire logic macro_enter = (state_q == HALT) && !nmi_edge && !mask_wake && macro_wake;

  // ------------------------------------------------------------
  // pending set and clear, set wins
  // ------------------------------------------------------------
  wire logic nmi_pend_set = defer_nmi || (nmi_edge && state_q != HALT && !nmi_can_accept);
  wire logic nmi_pend_clr = vec_nmi_d;
  wire logic mask_pend_clr = vec_mask_d && !mask_now;
  wire logic resume_d = (wake_now || macro_mask) && !vec_nmi_d && !vec_mask_d;
  wire logic vec_mask_only = vec_mask_d && !vec_nmi_d;

  // ------------------------------------------------------------
  // registered wake state
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= RUN;
    end else begin
      state_q <= state_d;
    end
  end

  // previous pin level for edge detection
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      nmi_level_q <= 1'b0;
    end else begin
      nmi_level_q <= nmi_level;
    end
  end

  // maskable request taken once so mask and priority are stable
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      req_q <= '0;
    end else begin
      req_q <= mask_req;
    end
  end

  // ------------------------------------------------------------
  // pending requests
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      nmi_pend_q <= 1'b0;
    end else if (nmi_pend_set) begin
      nmi_pend_q <= 1'b1;
    end else if (nmi_pend_clr) begin
      nmi_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mask_pend_q <= 1'b0;
    end else if (defer_mask) begin
      mask_pend_q <= 1'b1;
    end else if (mask_pend_clr) begin
      mask_pend_q <= 1'b0;
    end
  end

  // priority of the deferred request, used when it is taken later
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      mask_prio_q <= 2'h0;
    end else if (defer_mask) begin
      mask_prio_q <= defer_prio;
    end
  end

  // macro source priority, req_q has moved on by the end of the transfer
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      macro_prio_q <= 2'h0;
    end else if (macro_enter) begin
      macro_prio_q <= req_q.prio;
    end
  end

  // ------------------------------------------------------------
  // one cycle commands to the core
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      resume_q <= 1'b0;
    end else begin
      resume_q <= resume_d;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      vec_nmi_q <= 1'b0;
    end else begin
      vec_nmi_q <= vec_nmi_d;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      vec_mask_q <= 1'b0;
    end else begin
      vec_mask_q <= vec_mask_only;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      macro_start_q <= 1'b0;
    end else begin
      macro_start_q <= macro_enter;
    end
  end

  assign halted = (state_q != RUN);
  assign resume_next = resume_q;
  assign vector_nmi = vec_nmi_q;
  assign vector_mask = vec_mask_q;
  assign macro_start = macro_start_q;
  assign nmi_pending = nmi_pend_q;
  assign mask_pending = mask_pend_q;

  // ------------------------------------------------------------
  // external bus hold
  // ------------------------------------------------------------
  halt_bus_hold u_bus_hold (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .halted(halted),
    .core_bus(core_bus),
    .pin_bus(pin_bus)
  );
endmodule

/* inc/halt_release_defines.svh */
/*
  priority, halt request and strobe encodings for the halt release control block.
  assumes nothing beyond a system verilog compiler.
*/
`ifndef HALT_RELEASE_DEFINES_SVH
`define HALT_RELEASE_DEFINES_SVH
`define PRIO_LEVEL3 2'h3
`define HALT_ENTER_VALUE 1'h1
`define VEC_END_HALT_AGAIN 1'h1
`define ADDR_STROBE_HALT 1'h0
`define RW_STROBE_HALT 1'h1
`endif

/* inc/halt_release_pkg.sv */
/*
  types shared by the halt release control block.
  assumes the defines header is on the include path.
*/
package halt_release_pkg;
  typedef struct packed {
    logic valid;
    logic source_mask_bit;
    logic [1:0] prio;
    logic macro;
  } mask_req_type;

  typedef struct packed {
    logic running;
    logic [1:0] prio;
  } isr_state_type;

  typedef struct packed {
    logic [7:0] muxed_bus_lines;
    logic [19:0] upper_address_lines;
    logic address_strobe;
    logic rd_strobe_n;
    logic wr_strobe_n;
    logic wait_oe;
  } bus_pins_type;
endpackage

/* src/wake_pin_sync.sv */
/*
  three flop synchroniser for pin level wake inputs.
  assumes an asynchronous level from outside the clock domain.
*/
`timescale 1ns/1ps
module wake_pin_sync #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // pin side
  input wire logic [WIDTH-1:0] pin_async,
  output logic [WIDTH-1:0] pin_level
);
  logic [WIDTH-1:0] s1_q;
  logic [WIDTH-1:0] s2_q;
  logic [WIDTH-1:0] s3_q;
  logic [WIDTH-1:0] level_q;
  wire logic [WIDTH-1:0] agree = ~(s2_q ^ s3_q);
  wire logic [WIDTH-1:0] level_d = (agree & s2_q) | (~agree & level_q);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      level_q <= '0;
    end else begin
      s1_q <= pin_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_q <= level_d;
    end
  end
  assign pin_level = level_q;
endmodule

/* src/halt_bus_hold.sv */
/*
  holds the external expansion bus pins while halted.
  assumes live bus values come from the core on sys_clk.
*/
`timescale 1ns/1ps
`include "halt_release_defines.svh"
module halt_bus_hold
  import halt_release_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // control
  input wire logic halted,
  input wire bus_pins_type core_bus,
  // pins
  output bus_pins_type pin_bus
);
  bus_pins_type held_q;
  bus_pins_type held_d;
  bus_pins_type out_q;

  always_comb begin
    held_d = core_bus;
    held_d.address_strobe = `ADDR_STROBE_HALT;
    held_d.rd_strobe_n = `RW_STROBE_HALT;
    held_d.wr_strobe_n = `RW_STROBE_HALT;
    held_d.wait_oe = 1'b0;
  end

  // latch last address/data before halt, freeze while halted
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      held_q <= '0;
      out_q <= '0;
    end else begin
      if (!halted) begin
        held_q <= held_d;
      end
      out_q <= halted ? held_q : core_bus;
    end
  end
  assign pin_bus = out_q;
endmodule

/* sim/halt_mode_release_control_asserts.sv */
/*
  concurrent checks on the halt release control ports.
  assumes it is bound to the top module by the bind below.
*/
`timescale 1ns/1ps
module halt_mode_release_control_asserts
  import halt_release_pkg::*;
(
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // inputs
  input wire logic halt_write,
  input wire logic halt_request_bit,
  input wire logic global_accept_flag,
  input wire logic level3_priority_select,
  input wire isr_state_type mask_isr,
  input wire logic nmi_pin,
  input wire mask_req_type mask_req,
  input wire logic macro_done,
  input wire logic macro_end_met,
  input wire logic vector_on_end_disable,
  // outputs
  input wire logic halted,
  input wire logic resume_next,
  input wire logic vector_mask,
  input wire logic macro_start,
  input wire logic mask_pending,
  input wire bus_pins_type pin_bus
);
  default clocking @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);
  // unmasked request while halted, and whether it may be taken now
  wire unm = halted && mask_req.valid && !mask_req.source_mask_bit && !nmi_pin;
  wire acc = !mask_isr.running || mask_isr.prio > mask_req.prio ||
             (mask_isr.prio == 2'h3 && mask_req.prio == 2'h3 && !level3_priority_select);
  property p_enter; halt_write && halt_request_bit && !halted |=> halted; endproperty
  a_enter: assert property (p_enter) else $error("halt not entered");
  property p_strobe; halted && $past(halted) |-> pin_bus.address_strobe == 1'h0 &&
    pin_bus.rd_strobe_n && pin_bus.wr_strobe_n && !pin_bus.wait_oe; endproperty
  a_strobe: assert property (p_strobe) else $error("halt strobe levels wrong");
  property p_hold; halted && $past(halted) |=> !halted ||
    $stable({pin_bus.muxed_bus_lines, pin_bus.upper_address_lines}); endproperty
  a_hold: assert property (p_hold) else $error("bus lines moved in halt");
  property p_keep; (halted && !nmi_pin && !macro_done &&
    !(mask_req.valid && !mask_req.source_mask_bit))[*5] |=> halted; endproperty
  a_keep: assert property (p_keep) else $error("halt left without wake");
  property p_accept; unm && !mask_req.macro && global_accept_flag && acc |-> ##2 vector_mask && !halted; endproperty
  a_accept: assert property (p_accept) else $error("wake not vectored");
  property p_defer; unm && !mask_req.macro && global_accept_flag && !acc |->
    ##2 resume_next && !vector_mask ##1 mask_pending; endproperty
  a_defer: assert property (p_defer) else $error("wake not deferred");
  property p_macro; unm && mask_req.macro |-> ##2 macro_start && halted; endproperty
  a_macro: assert property (p_macro) else $error("macro not started");
  property p_again; macro_done && !(macro_end_met && !vector_on_end_disable) |=> halted; endproperty
  a_again: assert property (p_again) else $error("no return to halt");
endmodule
bind halt_mode_release_control halt_mode_release_control_asserts u_halt_mode_release_control_asserts (.*);

/* sim/macro_engine_model.sv */
/*
  macro transfer engine model: one done pulse two cycles after each start.
  assumes the bench sets the end condition level.
*/
`timescale 1ns/1ps
module macro_engine_model (
  // clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // bench and design side
  input wire logic end_cfg,
  input wire logic macro_start,
  output logic macro_done,
  output logic macro_end_met
);
  logic [1:0] dly_q;
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      dly_q <= 2'h0;
    end else begin
      dly_q <= {dly_q[0], macro_start};
    end
  end
  assign macro_done = dly_q[1];
  // end flag only meaningful with done, otherwise shown inverted
  assign macro_end_met = macro_done ? end_cfg : ~end_cfg;
endmodule

/* sim/halt_mode_release_control_tb.sv */
/*
  self-checking bench for halt entry and release.
  assumes the design, package and macro engine model are compiled first.
*/
`timescale 1ns/1ps
module halt_mode_release_control_tb;
  import halt_release_pkg::*;
  logic sys_clk, resetn, halt_request_bit, halt_write, global_accept_flag, level3_priority_select;
  logic nmi_pin_isr_running, nmi_pin, watchdog_req, vector_on_end_disable, end_cfg, macro_done;
  logic halted, resume_next, vector_nmi, vector_mask, macro_start, nmi_pending, mask_pending, macro_end_met;
  isr_state_type nmi_isr, mask_isr;
  mask_req_type mask_req;
  bus_pins_type core_bus, pin_bus;
  int failures, n_tests;
  localparam bus_pins_type bus_a = '{8'h5a, 20'h12345, 1'h1, 1'h0, 1'h0, 1'h1};
  localparam bus_pins_type pin_a = '{8'h5a, 20'h12345, 1'h0, 1'h1, 1'h1, 1'h0};
  // {nmi, routine running, routine prio, request prio, select, accept flag, own nmi routine, vectored}
  localparam logic [9:0] cases [10] = '{10'h015, 10'h195, 10'h1f5, 10'h1fc, 10'h124,
                                        10'h010, 10'h201, 10'h345, 10'h346, 10'h304};
  halt_mode_release_control u_halt_mode_release_control (.*);
  macro_engine_model u_macro_engine_model (.*);
  initial begin
    sys_clk = 1'h0;
    forever #50 sys_clk = ~sys_clk;
  end
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk_bit(input logic got, input logic exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic chk_bus(input bus_pins_type got, input bus_pins_type exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t bus %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic reset_dut;
    if ($time > 0) @(posedge sys_clk);
    resetn <= 1'h0;
    {halt_request_bit, halt_write, global_accept_flag, level3_priority_select} <= 4'h0;
    {nmi_pin_isr_running, nmi_pin, watchdog_req, vector_on_end_disable, end_cfg} <= 5'h0;
    {nmi_isr, mask_isr, mask_req} <= '0;
    core_bus <= bus_a;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'h1;
  endtask
  task automatic wait_cmd;
    for (int i = 0; i < 12; i++) begin
      @(negedge sys_clk);
      if ((vector_nmi | vector_mask | resume_next | macro_start) === 1'h1) return;
    end
    failures++;
    $display("ERROR %0t no command from the block", $time);
    wrap_up;
  endtask
  task automatic enter_halt;
    @(posedge sys_clk);
    halt_request_bit <= 1'h1;
    halt_write <= 1'h1;
    @(posedge sys_clk);
    halt_write <= 1'h0;
    core_bus <= ~bus_a;
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    chk_bit(halted, 1'h1);
    chk_bus(pin_bus, pin_a);
    @(posedge sys_clk);
  endtask
  task automatic run_case(input logic [9:0] c);
    reset_dut;
    level3_priority_select <= c[3];
    global_accept_flag <= c[2];
    nmi_pin_isr_running <= c[1];
    nmi_isr <= '{c[8] & c[9], c[7:6]};
    mask_isr <= '{c[8] & ~c[9], c[7:6]};
    enter_halt;
    if (c[9]) nmi_pin <= 1'h1;
    else mask_req <= '{1'h1, 1'h0, c[5:4], 1'h0};
    @(posedge sys_clk);
    mask_req <= '0;
    wait_cmd;
    chk_bit(vector_nmi | vector_mask, c[0]);
    chk_bit(halted, 1'h0);
    if (!c[0] && c[2]) begin
      @(negedge sys_clk);
      chk_bit(nmi_pending | mask_pending, 1'h1);
      @(posedge sys_clk);
      {nmi_isr, mask_isr, nmi_pin_isr_running} <= '0;
      wait_cmd;
      chk_bit(vector_nmi | vector_mask, 1'h1);
    end
  endtask
  // c = {end condition met, vector on end disabled, wake expected}
  task automatic run_macro(input logic [2:0] c);
    reset_dut;
    global_accept_flag <= 1'h1;
    end_cfg <= c[2];
    vector_on_end_disable <= c[1];
    enter_halt;
    mask_req <= '{1'h1, 1'h0, 2'h1, 1'h1};
    @(posedge sys_clk);
    mask_req <= '0;
    wait_cmd;
    chk_bit(macro_start & halted, 1'h1);
    repeat (8) @(posedge sys_clk);
    @(negedge sys_clk);
    chk_bit(halted, ~c[0]);
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    failures = 0;
    n_tests = 0;
    reset_dut;
    enter_halt;
    mask_req <= '{1'h1, 1'h1, 2'h0, 1'h0};
    watchdog_req <= 1'h1;
    repeat (3) @(posedge sys_clk);
    mask_req <= '{1'h1, 1'h1, 2'h0, 1'h1};
    repeat (3) @(posedge sys_clk);
    @(negedge sys_clk);
    chk_bit(halted, 1'h1);
    reset_dut;
    @(negedge sys_clk);
    chk_bit(halted, 1'h0);
    foreach (cases[i]) run_case(cases[i]);
    run_macro(3'h0);
    run_macro(3'h6);
    run_macro(3'h5);
    wrap_up;
  end
endmodule
